// ### hw/prc_config_regs.sv
// Configuration register bank with test, mirror, RGMII and 100BASE-TX controls behind AXI4-Lite.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps

module prc_config_regs
#(
   parameter bit LARGE_PACKAGE = 1'b0
)
(
   // Clock and reset.
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // Strap levels sampled when reset ends.
   input  wire logic [1:0]            strap_rx_ctrl_mode,
   input  wire logic                  strap_port_mirror,
   input  wire logic                  strap_rgmii_enable,
   // AXI4-Lite write address and data.
   input  wire logic [prc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // AXI4-Lite read.
   input  wire logic [prc_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // Configuration levels to the datapath.
   output prc_pkg::prc_cfg_type       cfg,
   output logic                       test_mode_active,
   output logic                       strap_test_request_n
);

   // ==========================================================
   // Helpers
   // ==========================================================

   // Byte address of a register index, four bytes per register.
   function automatic logic [prc_pkg::ADDR_W-1:0] byte_addr(input logic [7:0] idx);
      byte_addr = {idx, 2'b00};
   endfunction : byte_addr

   // Merges a 16-bit register image under byte strobes.
   function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] d,
                                           input logic [3:0] strb);
      merge16 = old_v;
      if (strb[0])
      begin
         merge16[7:0] = d[7:0];
      end
      if (strb[1])
      begin
         merge16[15:8] = d[15:8];
      end
   endfunction : merge16

   prc_pkg::prc_state_type st_reg;
   prc_pkg::prc_state_type st_next;
   logic [15:0]            img_test;
   logic [15:0]            img_rgmii;
   logic [15:0]            img_rgmii_two;
   logic [15:0]            img_fast;
   logic [15:0]            img_strap;

   // ==========================================================
   // Read images
   // ==========================================================

   // Builds each register's read view from the stored fields.
   always_comb
   begin
      img_test = prc_pkg::TEST_MIRROR_FIXED;
      img_test[8] = st_reg.cfg.test_reserved_rw;
      img_test[prc_pkg::POS_TEST_OVERRIDE] = st_reg.cfg.internal_test_override;
      img_test[prc_pkg::POS_MIRROR] = st_reg.cfg.port_mirror;
      img_rgmii = 16'h0000;
      img_rgmii[prc_pkg::POS_RGMII_EN] = st_reg.cfg.rgmii_enable;
      img_rgmii[prc_pkg::POS_RX_THR +: 2] = st_reg.cfg.receive_fifo_half_threshold;
      img_rgmii[prc_pkg::POS_TX_THR +: 2] = st_reg.cfg.transmit_fifo_half_threshold;
      img_rgmii[prc_pkg::POS_TX_DELAY] = st_reg.cfg.tx_clock_shift;
      img_rgmii[prc_pkg::POS_RX_DELAY] = st_reg.cfg.rx_clock_shift;
      img_rgmii_two = 16'h0000;
      img_rgmii_two[prc_pkg::POS_ASYNC_SKIP] = st_reg.cfg.async_fifo_skip_enable;
      img_fast = 16'h0000;
      img_fast[prc_pkg::POS_DESC_TIMER_DIS] = st_reg.cfg.descrambler_timer_disable;
      img_fast[prc_pkg::POS_DESC_RECOVERY +: 4] = st_reg.cfg.descrambler_recovery_time;
      img_fast[prc_pkg::POS_FORCE_GOOD] = st_reg.cfg.force_good_link;
      img_fast[prc_pkg::POS_ENH_MLT3] = st_reg.cfg.enhanced_three_level_detect;
      img_fast[prc_pkg::POS_ENH_GAP] = st_reg.cfg.enhanced_gap_detect;
      img_fast[prc_pkg::POS_DEC_SKIP] = st_reg.cfg.receive_decoder_skip;
      img_fast[prc_pkg::POS_SCR_OFF] = st_reg.cfg.scrambler_off;
      img_fast[prc_pkg::POS_ODD_NIBBLE] = st_reg.cfg.odd_nibble_detect;
      img_fast[prc_pkg::POS_EARLY_VALID] = st_reg.cfg.early_receive_valid_enable;
      img_strap = 16'h0000;
      img_strap[prc_pkg::POS_STRAP_TEST_REQ] = ~st_reg.test_request;
   end

   // ==========================================================
   // Next state
   // ==========================================================

   // Handles strap capture, the write and read channels and field updates.
   always_comb
   begin
      logic [15:0] nv;
      logic        wr_go;
      logic        rd_go;
      logic        hit;
      nv = 16'h0000;
      st_next = st_reg;
      hit = 1'b0;
      wr_go = 1'b0;
      rd_go = 1'b0;
      // Strap capture on the first edge after reset releases.
      if (!st_reg.strap_taken)
      begin
         st_next.strap_taken = 1'b1;
         st_next.test_request = |strap_rx_ctrl_mode;
         st_next.cfg.internal_test_override = |strap_rx_ctrl_mode;
         st_next.cfg.port_mirror = strap_port_mirror;
         st_next.cfg.rgmii_enable = LARGE_PACKAGE ? strap_rgmii_enable : 1'b1;
      end
      // Address and data are caught separately, in either order.
      if (st_reg.axi.awready && s_axi_awvalid)
      begin
         st_next.aw_held = 1'b1;
         st_next.aw_addr = s_axi_awaddr;
      end
      if (st_reg.axi.wready && s_axi_wvalid)
      begin
         st_next.w_held = 1'b1;
         st_next.w_data = s_axi_wdata;
         st_next.w_strb = s_axi_wstrb;
      end
      st_next.axi.awready = !st_next.aw_held && !st_reg.axi.bvalid;
      st_next.axi.wready = !st_next.w_held && !st_reg.axi.bvalid;
      wr_go = st_reg.aw_held && st_reg.w_held && !st_reg.axi.bvalid && st_reg.strap_taken;
      if (wr_go)
      begin
         hit = 1'b1;
         if (st_reg.aw_addr == byte_addr(prc_pkg::IDX_TEST_MIRROR))
         begin
            nv = merge16(img_test, st_reg.w_data, st_reg.w_strb);
            st_next.cfg.test_reserved_rw = nv[8];
            st_next.cfg.internal_test_override = nv[prc_pkg::POS_TEST_OVERRIDE];
            st_next.cfg.port_mirror = nv[prc_pkg::POS_MIRROR];
         end
         else if (st_reg.aw_addr == byte_addr(prc_pkg::IDX_RGMII_CTL))
         begin
            nv = merge16(img_rgmii, st_reg.w_data, st_reg.w_strb);
            st_next.cfg.rgmii_enable = nv[prc_pkg::POS_RGMII_EN];
            st_next.cfg.receive_fifo_half_threshold = nv[prc_pkg::POS_RX_THR +: 2];
            st_next.cfg.transmit_fifo_half_threshold = nv[prc_pkg::POS_TX_THR +: 2];
            st_next.cfg.tx_clock_shift = nv[prc_pkg::POS_TX_DELAY];
            st_next.cfg.rx_clock_shift = nv[prc_pkg::POS_RX_DELAY];
         end
         else if (st_reg.aw_addr == byte_addr(prc_pkg::IDX_RGMII_CTL_TWO))
         begin
            nv = merge16(img_rgmii_two, st_reg.w_data, st_reg.w_strb);
            st_next.cfg.async_fifo_skip_enable = nv[prc_pkg::POS_ASYNC_SKIP];
         end
         else if (st_reg.aw_addr == byte_addr(prc_pkg::IDX_FAST_ETH))
         begin
            nv = merge16(img_fast, st_reg.w_data, st_reg.w_strb);
            st_next.cfg.descrambler_timer_disable = nv[prc_pkg::POS_DESC_TIMER_DIS];
            st_next.cfg.descrambler_recovery_time = nv[prc_pkg::POS_DESC_RECOVERY +: 4];
            st_next.cfg.force_good_link = nv[prc_pkg::POS_FORCE_GOOD];
            st_next.cfg.enhanced_three_level_detect = nv[prc_pkg::POS_ENH_MLT3];
            st_next.cfg.enhanced_gap_detect = nv[prc_pkg::POS_ENH_GAP];
            st_next.cfg.receive_decoder_skip = nv[prc_pkg::POS_DEC_SKIP];
            st_next.cfg.scrambler_off = nv[prc_pkg::POS_SCR_OFF];
            st_next.cfg.odd_nibble_detect = nv[prc_pkg::POS_ODD_NIBBLE];
            st_next.cfg.early_receive_valid_enable = nv[prc_pkg::POS_EARLY_VALID];
         end
         else if (st_reg.aw_addr == byte_addr(prc_pkg::IDX_STRAP_STS_TWO))
         begin
            nv = img_strap;
         end
         else
         begin
            hit = 1'b0;
         end
         st_next.aw_held = 1'b0;
         st_next.w_held = 1'b0;
         st_next.axi.bvalid = 1'b1;
         st_next.axi.bresp = hit ? prc_pkg::AXI_OKAY : prc_pkg::AXI_SLVERR;
      end
      else if (st_reg.axi.bvalid && s_axi_bready)
      begin
         st_next.axi.bvalid = 1'b0;
         st_next.axi.awready = !st_reg.aw_held;
         st_next.axi.wready = !st_reg.w_held;
      end
      // Read channel: one read at a time, answer on the next edge.
      rd_go = st_reg.axi.arready && s_axi_arvalid;
      if (rd_go)
      begin
         st_next.axi.arready = 1'b0;
         st_next.axi.rvalid = 1'b1;
         st_next.axi.rresp = prc_pkg::AXI_OKAY;
         if (s_axi_araddr == byte_addr(prc_pkg::IDX_TEST_MIRROR))
         begin
            st_next.axi.rdata = {16'h0000, img_test};
         end
         else if (s_axi_araddr == byte_addr(prc_pkg::IDX_RGMII_CTL))
         begin
            st_next.axi.rdata = {16'h0000, img_rgmii};
         end
         else if (s_axi_araddr == byte_addr(prc_pkg::IDX_RGMII_CTL_TWO))
         begin
            st_next.axi.rdata = {16'h0000, img_rgmii_two};
         end
         else if (s_axi_araddr == byte_addr(prc_pkg::IDX_FAST_ETH))
         begin
            st_next.axi.rdata = {16'h0000, img_fast};
         end
         else if (s_axi_araddr == byte_addr(prc_pkg::IDX_STRAP_STS_TWO))
         begin
            st_next.axi.rdata = {16'h0000, img_strap};
         end
         else
         begin
            st_next.axi.rdata = prc_pkg::ZERO_WORD;
            st_next.axi.rresp = prc_pkg::AXI_SLVERR;
         end
      end
      else if (st_reg.axi.rvalid && s_axi_rready)
      begin
         st_next.axi.rvalid = 1'b0;
         st_next.axi.arready = st_reg.strap_taken;
      end
      else if (!st_reg.axi.rvalid)
      begin
         st_next.axi.arready = st_reg.strap_taken;
      end
   end

   // ==========================================================
   // State register
   // ==========================================================

   // Loads documented defaults under reset and the next state otherwise.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_reg <= '0;
         st_reg.cfg.receive_fifo_half_threshold <= prc_pkg::RST_RX_THR;
         st_reg.cfg.transmit_fifo_half_threshold <= prc_pkg::RST_TX_THR;
         st_reg.cfg.descrambler_recovery_time <= prc_pkg::RST_DESC_RECOVERY;
         st_reg.cfg.enhanced_three_level_detect <= prc_pkg::RST_ENH_MLT3;
         st_reg.cfg.rgmii_enable <= 1'b1;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================

   // All outputs come from the state register; strap_test_request_n is the inverted test_request.
   assign s_axi_awready        = st_reg.axi.awready;
   assign s_axi_wready         = st_reg.axi.wready;
   assign s_axi_bvalid         = st_reg.axi.bvalid;
   assign s_axi_bresp          = st_reg.axi.bresp;
   assign s_axi_arready        = st_reg.axi.arready;
   assign s_axi_rvalid         = st_reg.axi.rvalid;
   assign s_axi_rresp          = st_reg.axi.rresp;
   assign s_axi_rdata          = st_reg.axi.rdata;
   assign cfg                  = st_reg.cfg;
   assign test_mode_active     = st_reg.cfg.internal_test_override;
   assign strap_test_request_n = ~st_reg.test_request;

endmodule : prc_config_regs

// ### hw/prc_pkg.sv
// Package with offsets, field positions, reset values and carrier types of the configuration bank.
package prc_pkg;

   // ==========================================================
   // Register indices and address width
   // ==========================================================
   localparam logic [7:0]  IDX_TEST_MIRROR   = 8'h31;
   localparam logic [7:0]  IDX_RGMII_CTL     = 8'h32;
   localparam logic [7:0]  IDX_RGMII_CTL_TWO = 8'h33;
   localparam logic [7:0]  IDX_FAST_ETH      = 8'h43;
   localparam logic [7:0]  IDX_STRAP_STS_TWO = 8'h6F;
   localparam int          ADDR_W            = 10;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int POS_TEST_OVERRIDE   = 7;
   localparam int POS_MIRROR          = 0;
   localparam int POS_RGMII_EN        = 7;
   localparam int POS_RX_THR          = 5;
   localparam int POS_TX_THR          = 3;
   localparam int POS_TX_DELAY        = 1;
   localparam int POS_RX_DELAY        = 0;
   localparam int POS_ASYNC_SKIP      = 4;
   localparam int POS_DESC_TIMER_DIS  = 11;
   localparam int POS_DESC_RECOVERY   = 7;
   localparam int POS_FORCE_GOOD      = 6;
   localparam int POS_ENH_MLT3        = 5;
   localparam int POS_ENH_GAP         = 4;
   localparam int POS_DEC_SKIP        = 3;
   localparam int POS_SCR_OFF         = 2;
   localparam int POS_ODD_NIBBLE      = 1;
   localparam int POS_EARLY_VALID     = 0;
   localparam int POS_STRAP_TEST_REQ  = 8;

   // ==========================================================
   // Reset values, AXI response codes and constant read-only patterns
   // ==========================================================
   localparam logic [15:0] TEST_MIRROR_FIXED = 16'h1010;
   localparam logic [1:0]  RST_RX_THR        = 2'h2;
   localparam logic [1:0]  RST_TX_THR        = 2'h2;
   localparam logic [3:0]  RST_DESC_RECOVERY = 4'hF;
   localparam logic        RST_ENH_MLT3      = 1'b1;
   localparam logic [1:0]  AXI_OKAY          = 2'h0;
   localparam logic [1:0]  AXI_SLVERR        = 2'h2;
   localparam logic [31:0] ZERO_WORD         = 32'h0000_0000;

   // Descrambler packet limit in microseconds, clock rate in MHz and the limit in cycles.
   localparam int          DESC_LIMIT_US     = 1500;
   localparam int          CLK_MHZ           = 100;
   localparam int          DESC_LIMIT_CYC    = DESC_LIMIT_US * CLK_MHZ;

   // ==========================================================
   // Carriers
   // ==========================================================
   typedef struct packed {
      logic       internal_test_override;
      logic       test_reserved_rw;
      logic       port_mirror;
      logic       rgmii_enable;
      logic [1:0] receive_fifo_half_threshold;
      logic [1:0] transmit_fifo_half_threshold;
      logic       tx_clock_shift;
      logic       rx_clock_shift;
      logic       async_fifo_skip_enable;
      logic       descrambler_timer_disable;
      logic [3:0] descrambler_recovery_time;
      logic       force_good_link;
      logic       enhanced_three_level_detect;
      logic       enhanced_gap_detect;
      logic       receive_decoder_skip;
      logic       scrambler_off;
      logic       odd_nibble_detect;
      logic       early_receive_valid_enable;
   } prc_cfg_type;

   typedef struct packed {
      logic       awready;
      logic       wready;
      logic       bvalid;
      logic [1:0] bresp;
      logic       arready;
      logic       rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } prc_axi_out_type;

   typedef struct packed {
      logic              aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_held;
      logic [31:0]       w_data;
      logic [3:0]        w_strb;
      logic              strap_taken;
      logic              test_request;
      prc_cfg_type       cfg;
      prc_axi_out_type   axi;
   } prc_state_type;

endpackage : prc_pkg

// ### testbench/prc_config_regs_sva.sv
// Checker of handshake, reset and configuration timing at the bank's ports.
`timescale 1ns/10ps

module prc_config_regs_sva
(
   // Clock and reset.
   input wire logic                 aclk,
   input wire logic                 aresetn,
   // Strap pin watched at the end of reset.
   input wire logic [1:0]           strap_rx_ctrl_mode,
   // Write channels.
   input wire logic                 s_axi_awvalid,
   input wire logic                 s_axi_awready,
   input wire logic                 s_axi_wvalid,
   input wire logic                 s_axi_wready,
   input wire logic [1:0]           s_axi_bresp,
   input wire logic                 s_axi_bvalid,
   input wire logic                 s_axi_bready,
   // Read channels.
   input wire logic                 s_axi_arvalid,
   input wire logic                 s_axi_arready,
   input wire logic [31:0]          s_axi_rdata,
   input wire logic [1:0]           s_axi_rresp,
   input wire logic                 s_axi_rvalid,
   input wire logic                 s_axi_rready,
   // Configuration levels.
   input wire prc_pkg::prc_cfg_type cfg,
   input wire logic                 test_mode_active
);
   // =========================================================
   // Common clocking and request sequences
   // =========================================================
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // A write is taken when address and data meet their readies together.
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // A read is taken when the address meets its ready.
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence

   // =========================================================
   // Properties
   // =========================================================
   write_answer_a:
      assert property (wr_taken |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
      else $error("Write response missing two cycles after the take.");
   read_answer_a:
      assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
      else $error("Read data missing one cycle after the take.");
   bresp_hold_a:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write response dropped before it was accepted.");
   rdata_hold_a:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("Read data changed before it was accepted.");
   upper_zero_a:
      assert property (s_axi_rvalid && s_axi_rresp == prc_pkg::AXI_OKAY |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("Upper half of read word is not zero.");
   refused_zero_a:
      assert property (s_axi_rvalid && s_axi_rresp == prc_pkg::AXI_SLVERR |-> s_axi_rdata == prc_pkg::ZERO_WORD)
      else $error("Refused read returned data.");
   test_mode_a:
      assert property ($rose(aresetn) |=> test_mode_active == ($past(strap_rx_ctrl_mode) != 2'b00))
      else $error("Test mode does not follow the receive-control strap.");
   cfg_on_write_a:
      assert property ($changed(cfg) && $past(aresetn, 2) |-> $rose(s_axi_bvalid))
      else $error("Configuration changed without a completed write.");
   reset_values_a:
      assert property (disable iff (1'b0) !aresetn |=> cfg.receive_fifo_half_threshold == 2'h2 &&
         cfg.transmit_fifo_half_threshold == 2'h2 && cfg.descrambler_recovery_time == 4'hF &&
         cfg.enhanced_three_level_detect && !cfg.internal_test_override)
      else $error("Configuration not at reset values during reset.");
endmodule : prc_config_regs_sva

bind prc_config_regs prc_config_regs_sva i_sva (.aclk(aclk), .aresetn(aresetn),
   .strap_rx_ctrl_mode(strap_rx_ctrl_mode),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .cfg(cfg), .test_mode_active(test_mode_active));

// ### testbench/prc_mac_model.sv
// Board and MAC side model: strap pins and a readiness flag seen by the MAC.
`timescale 1ns/10ps

module prc_mac_model
(
   // Clock.
   input wire logic                 aclk,
   // Strap settings chosen for the board.
   input wire logic [3:0]           board_straps,
   // Strap pins toward the bank.
   output logic [1:0]               strap_rx_ctrl_mode,
   output logic                     strap_port_mirror,
   output logic                     strap_rgmii_enable,
   // Configuration seen from the MAC side.
   input wire prc_pkg::prc_cfg_type cfg,
   input wire logic                 test_mode_active,
   output logic                     mac_ready
);
   // Strap pins are plain board levels.
   assign strap_rx_ctrl_mode = board_straps[1:0];
   assign strap_port_mirror  = board_straps[2];
   assign strap_rgmii_enable = board_straps[3];

   // The MAC may send only while the interface is on and no test mode runs.
   always_ff @(posedge aclk)
   begin
      mac_ready <= cfg.rgmii_enable && !test_mode_active;
   end
endmodule : prc_mac_model

// ### testbench/tb_prc_config_regs.sv
// Self-checking bench of the configuration bank over AXI4-Lite.
`timescale 1ns/10ps

module tb_prc_config_regs;
   logic                 aclk;
   logic                 aresetn;
   logic [3:0]           board_straps;
   logic [1:0]           strap_rx_ctrl_mode;
   logic                 strap_port_mirror;
   logic                 strap_rgmii_enable;
   logic [9:0]           awaddr;
   logic [9:0]           araddr;
   logic [31:0]          wdata;
   logic [31:0]          rdata;
   logic [3:0]           wstrb;
   logic [1:0]           bresp;
   logic [1:0]           rresp;
   logic                 awvalid, awready, wvalid, wready, bvalid, bready;
   logic                 arvalid, arready, rvalid, rready;
   logic                 test_mode_active, strap_test_request_n, mac_ready;
   prc_pkg::prc_cfg_type cfg;
   int                   n_mismatch;
   int                   checks_done;

   // Design under test with the small package.
   prc_config_regs #(.LARGE_PACKAGE(1'b0)) i_dut (.aclk(aclk), .aresetn(aresetn),
      .strap_rx_ctrl_mode(strap_rx_ctrl_mode), .strap_port_mirror(strap_port_mirror),
      .strap_rgmii_enable(strap_rgmii_enable), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cfg(cfg),
      .test_mode_active(test_mode_active), .strap_test_request_n(strap_test_request_n));

   // Board and MAC side.
   prc_mac_model i_mac (.aclk(aclk), .board_straps(board_straps), .strap_rx_ctrl_mode(strap_rx_ctrl_mode),
      .strap_port_mirror(strap_port_mirror), .strap_rgmii_enable(strap_rgmii_enable), .cfg(cfg),
      .test_mode_active(test_mode_active), .mac_ready(mac_ready));

   // Clock of 10 ns period.
   always #5 aclk = ~aclk;

   // Compares one value and counts the outcome.
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Writes one word; a slow master raises bready only after bvalid.
   task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er,
                     input bit slow);
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= s;
      wvalid  <= 1'b1;
      bready  <= !slow;
      do
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && !bready) bready <= 1'b1;
      end
      while (!(bvalid && bready));
      bready <= 1'b0;
      check("bresp", {30'h0, bresp}, {30'h0, er});
   endtask : wr

   // Reads one word and compares data and response.
   task automatic rchk(input logic [9:0] a, input logic [31:0] exp, input logic [1:0] er, input bit slow);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= !slow;
      do
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && !rready) rready <= 1'b1;
      end
      while (!(rvalid && rready));
      rready <= 1'b0;
      check("rdata", rdata, exp);
      check("rresp", {30'h0, rresp}, {30'h0, er});
   endtask : rchk

   // Prints the counts and the verdict, then ends the run.
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize

   // Cuts a hang short.
   initial
   begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      summarize();
   end

   // Main sequence.
   initial
   begin
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      board_straps = 4'h5;
      n_mismatch   = 0;
      checks_done  = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(10'h0C4, 32'h0000_1091, prc_pkg::AXI_OKAY, 1'b0);
      check("test_mode", {31'h0, test_mode_active}, 32'h1);
      check("strap_req_n", {31'h0, strap_test_request_n}, 32'h0);
      rchk(10'h1BC, 32'h0000_0000, prc_pkg::AXI_OKAY, 1'b1);
      rchk(10'h0C8, 32'h0000_00D0, prc_pkg::AXI_OKAY, 1'b0);
      rchk(10'h0CC, 32'h0000_0000, prc_pkg::AXI_OKAY, 1'b0);
      rchk(10'h10C, 32'h0000_07A0, prc_pkg::AXI_OKAY, 1'b0);
      check("mac_ready", {31'h0, mac_ready}, 32'h0);
      wr(10'h0C4, 32'h0000_0001, 4'h3, prc_pkg::AXI_OKAY, 1'b1);
      rchk(10'h0C4, 32'h0000_1011, prc_pkg::AXI_OKAY, 1'b0);
      check("test_mode", {31'h0, test_mode_active}, 32'h0);
      repeat (2) @(posedge aclk);
      check("mac_ready", {31'h0, mac_ready}, 32'h1);
      wr(10'h0C4, 32'hFFFF_FFFF, 4'hF, prc_pkg::AXI_OKAY, 1'b0);
      rchk(10'h0C4, 32'h0000_1191, prc_pkg::AXI_OKAY, 1'b0);
      wr(10'h0C8, 32'hFFFF_FFFF, 4'hF, prc_pkg::AXI_OKAY, 1'b0);
      rchk(10'h0C8, 32'h0000_00FB, prc_pkg::AXI_OKAY, 1'b0);
      check("rgmii_cfg", {25'h0, cfg.rgmii_enable, cfg.receive_fifo_half_threshold,
         cfg.transmit_fifo_half_threshold, cfg.tx_clock_shift, cfg.rx_clock_shift}, 32'h7F);
      wr(10'h0C8, 32'h0000_0004, 4'h3, prc_pkg::AXI_OKAY, 1'b0);
      rchk(10'h0C8, 32'h0000_0000, prc_pkg::AXI_OKAY, 1'b0);
      wr(10'h0CC, 32'hFFFF_FFFF, 4'hF, prc_pkg::AXI_OKAY, 1'b0);
      wr(10'h0CC, 32'h0000_0000, 4'h2, prc_pkg::AXI_OKAY, 1'b0);
      rchk(10'h0CC, 32'h0000_0010, prc_pkg::AXI_OKAY, 1'b0);
      check("skip", {31'h0, cfg.async_fifo_skip_enable}, 32'h1);
      // Walks a single one through every control bit of the 100 Mb/s register.
      for (int b = 0; b < 12; b++)
      begin
         wr(10'h10C, 32'h0000_0001 << b, 4'h3, prc_pkg::AXI_OKAY, 1'b0);
         rchk(10'h10C, 32'h0000_0001 << b, prc_pkg::AXI_OKAY, 1'b0);
         check("fast_cfg", {20'h0_0000, cfg[11:0]}, 32'h0000_0001 << b);
      end
      wr(10'h10C, 32'hFFFF_FFFF, 4'hF, prc_pkg::AXI_OKAY, 1'b0);
      wr(10'h10C, 32'h0000_0000, 4'h1, prc_pkg::AXI_OKAY, 1'b0);
      rchk(10'h10C, 32'h0000_0F00, prc_pkg::AXI_OKAY, 1'b0);
      wr(10'h100, 32'hFFFF_FFFF, 4'hF, prc_pkg::AXI_SLVERR, 1'b0);
      rchk(10'h100, 32'h0000_0000, prc_pkg::AXI_SLVERR, 1'b1);
      wr(10'h1BC, 32'hFFFF_FFFF, 4'hF, prc_pkg::AXI_OKAY, 1'b0);
      rchk(10'h1BC, 32'h0000_0000, prc_pkg::AXI_OKAY, 1'b0);
      // Second reset with no strap request and mirroring off.
      @(posedge aclk);
      aresetn      <= 1'b0;
      board_straps <= 4'h0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(10'h0C4, 32'h0000_1010, prc_pkg::AXI_OKAY, 1'b0);
      rchk(10'h1BC, 32'h0000_0100, prc_pkg::AXI_OKAY, 1'b0);
      rchk(10'h10C, 32'h0000_07A0, prc_pkg::AXI_OKAY, 1'b0);
      check("test_mode", {31'h0, test_mode_active}, 32'h0);
      summarize();
   end
endmodule : tb_prc_config_regs
